// ==== shared/qsg_pkg.sv ====
// How it works
// - Condition register mirrors live status, read-only
// - Unused condition bits always read zero
// - Bit 3 carries power subgroup summary
// - Bit 4 set while detector still cold
// - Bit 5 carries frequency subgroup summary
// - Bit 7 carries modulation subgroup summary
// - Bit 8 carries calibration subgroup summary
// - Bit 9 set on power-up self-test failure
// - Self-test bit holds until power-on reset
// - Bit 12 carries bit error tester summary
// - Condition query returns sum of set bits
// - Transition filters select rising/falling edges per bit
// - Filters written as weight sum, read back
// - Event bits latch filtered transitions until cleared
// - Event query returns contents then clears
// - Enabled set events drive status byte bit 3
// - Power enabled events form condition bit 3
`default_nettype none
package qsg_pkg;
    localparam int REG_W = 16;
    localparam int POWER_BIT = 3;
    localparam int COLD_BIT = 4;
    localparam int FREQ_BIT = 5;
    localparam int MOD_BIT = 7;
    localparam int CAL_BIT = 8;
    localparam int SELF_TEST_BIT = 9;
    localparam int ERR_TEST_BIT = 12;
    localparam logic [15:0] USED_MASK = 16'h13B8;
    localparam logic [15:0] PTR_RESET = 16'h13B8;
    localparam logic [15:0] NTR_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] EVENT_RESET = 16'h0000;
    localparam logic [15:0] COND_RESET = 16'h0000;
    localparam logic [15:0] RSP_RESET = 16'h0000;
    localparam logic SELF_TEST_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;

    typedef enum logic [3:0] {
        OP_QUERY_COND,
        OP_QUERY_EVENT,
        OP_WRITE_PTR,
        OP_QUERY_PTR,
        OP_WRITE_NTR,
        OP_QUERY_NTR,
        OP_WRITE_ENABLE,
        OP_QUERY_ENABLE,
        OP_WRITE_COND,
        OP_CLEAR_STATUS
    } qsg_op_e;

    typedef struct packed {
        qsg_op_e op;
        logic [15:0] value;
    } qsg_cmd_s;

    typedef struct packed {
        logic [15:0] events;
        logic [15:0] enable;
    } qsg_subgroup_s;

    typedef struct packed {
        qsg_subgroup_s power;
        qsg_subgroup_s freq;
        qsg_subgroup_s modul;
        qsg_subgroup_s cal;
        qsg_subgroup_s bitErrorTester;
    } qsg_subgroups_s;
endpackage
`default_nettype wire

// ==== logic/qsg_questionable_status.sv ====
`default_nettype none
module qsg_questionable_status
    import qsg_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Parsed remote commands
    input wire logic cmdValid,
    input var qsg_cmd_s cmd,
    // Answers to queries
    output logic rspValid,
    output logic [15:0] rspData,
    // Live status from same-clock logic
    input var qsg_subgroups_s subgroups,
    input wire logic detectorCold,
    input wire logic selfTestFail,
    // Status byte summary and register views
    output logic questionableSummary,
    output logic [15:0] conditionView,
    output logic [15:0] eventView
);

    // OR of a subgroup's enabled event bits
    function automatic logic summaryOf(input qsg_subgroup_s g);
        return |(g.events & g.enable);
    endfunction

    // True for the ops that put an answer on the response port
    function automatic logic answers(input qsg_op_e op);
        return op inside {OP_QUERY_COND, OP_QUERY_EVENT, OP_QUERY_PTR,
            OP_QUERY_NTR, OP_QUERY_ENABLE};
    endfunction

    logic selfTest_reg, selfTest_next;
    logic [15:0] cond_reg, cond_next;
    logic [15:0] ptr_reg, ptr_next;
    logic [15:0] ntr_reg, ntr_next;
    logic [15:0] enable_reg, enable_next;
    logic [15:0] event_reg, event_next;
    logic rspValid_reg, rspValid_next;
    logic [15:0] rspData_reg, rspData_next;
    logic summary_reg, summary_next;
    logic [15:0] rise, fall, caught;
    logic wrPtr, wrNtr, wrEnable, clearEvents, isQuery;
    logic [15:0] answer;
    logic powerSum, freqSum, modSum, calSum, errTestSum;

    // Command decode; one command per cycle at most
    always_comb
    begin
        wrPtr = 1'h0;
        wrNtr = 1'h0;
        wrEnable = 1'h0;
        clearEvents = 1'h0;
        isQuery = 1'h0;
        answer = rspData_reg;
        if (cmdValid)
        begin
            isQuery = answers(cmd.op);
            unique case (cmd.op)
                OP_QUERY_COND:
                begin
                    answer = cond_reg;
                end
                OP_QUERY_EVENT:
                begin
                    answer = event_reg;
                    clearEvents = 1'h1;
                end
                OP_WRITE_PTR:
                begin
                    wrPtr = 1'h1;
                end
                OP_QUERY_PTR:
                begin
                    answer = ptr_reg;
                end
                OP_WRITE_NTR:
                begin
                    wrNtr = 1'h1;
                end
                OP_QUERY_NTR:
                begin
                    answer = ntr_reg;
                end
                OP_WRITE_ENABLE:
                begin
                    wrEnable = 1'h1;
                end
                OP_QUERY_ENABLE:
                begin
                    answer = enable_reg;
                end
                // Condition is hardware-owned; writes are dropped
                OP_WRITE_COND: ;
                // Self-test bit, filters and enable are kept
                OP_CLEAR_STATUS:
                begin
                    clearEvents = 1'h1;
                end
                default: ;
            endcase
        end
    end

    // Self-test latch: only power-on reset drops it, clear-status never
    always_comb
    begin
        selfTest_next = selfTest_reg | selfTestFail;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            selfTest_reg <= SELF_TEST_RESET;
        end
        else
        begin
            selfTest_reg <= selfTest_next;
        end
    end

    // Subgroup summaries, rebuilt every cycle from enabled events
    always_comb
    begin
        powerSum = summaryOf(subgroups.power);
        freqSum = summaryOf(subgroups.freq);
        modSum = summaryOf(subgroups.modul);
        calSum = summaryOf(subgroups.cal);
        errTestSum = summaryOf(subgroups.bitErrorTester);
    end

    // Condition mirror, one cycle behind the live inputs
    always_comb
    begin
        cond_next = COND_RESET;
        cond_next[POWER_BIT] = powerSum;
        cond_next[COLD_BIT] = detectorCold;
        cond_next[FREQ_BIT] = freqSum;
        cond_next[MOD_BIT] = modSum;
        cond_next[CAL_BIT] = calSum;
        cond_next[SELF_TEST_BIT] = selfTest_next;
        cond_next[ERR_TEST_BIT] = errTestSum;
        cond_next = cond_next & USED_MASK;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cond_reg <= COND_RESET;
        end
        else
        begin
            cond_reg <= cond_next;
        end
    end

    // Rising-edge filter; unused bits store but can never fire
    always_comb
    begin
        ptr_next = ptr_reg;
        if (wrPtr)
        begin
            ptr_next = cmd.value;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ptr_reg <= PTR_RESET;
        end
        else
        begin
            ptr_reg <= ptr_next;
        end
    end

    // Falling-edge filter
    always_comb
    begin
        ntr_next = ntr_reg;
        if (wrNtr)
        begin
            ntr_next = cmd.value;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ntr_reg <= NTR_RESET;
        end
        else
        begin
            ntr_reg <= ntr_next;
        end
    end

    // Event enable mask for the status byte summary
    always_comb
    begin
        enable_next = enable_reg;
        if (wrEnable)
        begin
            enable_next = cmd.value;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            enable_reg <= ENABLE_RESET;
        end
        else
        begin
            enable_reg <= enable_next;
        end
    end

    // Edge filter and event latch; an edge in the clearing cycle wins
    always_comb
    begin
        rise = cond_next & ~cond_reg & ptr_reg;
        fall = ~cond_next & cond_reg & ntr_reg;
        caught = rise | fall;
        if (clearEvents)
        begin
            event_next = caught;
        end
        else
        begin
            event_next = event_reg | caught;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            event_reg <= EVENT_RESET;
        end
        else
        begin
            event_reg <= event_next;
        end
    end

    // Query answers; data holds until the next query
    always_comb
    begin
        rspValid_next = isQuery;
        rspData_next = answer;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rspValid_reg <= FLAG_RESET;
            rspData_reg <= RSP_RESET;
        end
        else
        begin
            rspValid_reg <= rspValid_next;
            rspData_reg <= rspData_next;
        end
    end

    // Summary moves on the same edge as the events behind it
    always_comb
    begin
        summary_next = |(event_next & enable_next);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            summary_reg <= FLAG_RESET;
        end
        else
        begin
            summary_reg <= summary_next;
        end
    end

    assign rspValid = rspValid_reg;
    assign rspData = rspData_reg;
    assign questionableSummary = summary_reg;
    assign conditionView = cond_reg;
    assign eventView = event_reg;

endmodule // qsg_questionable_status
`default_nettype wire

// ==== test/qsg_remote_ctl.sv ====
`default_nettype none
module qsg_remote_ctl
    import qsg_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Commands
    output var logic cmdValid,
    output var qsg_cmd_s cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cmdValid = 1'h0;
    initial cmd = '0;
    // Values are bit-weight sums
    task automatic send(input qsg_op_e op, input logic [15:0] v);
        @(posedge sys_clk);
        #1 cmdValid = 1'h1;
        cmd = '{op, v};
        @(posedge sys_clk);
        #1 cmdValid = 1'h0;
        cmd.value = ~v;
    endtask
endmodule // qsg_remote_ctl
`default_nettype wire

// ==== test/qsg_questionable_properties.sv ====
`default_nettype none
module qsg_questionable_properties
    import qsg_pkg::*;
(
    // Clock, reset, commands
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input var qsg_cmd_s cmd,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    // Status
    input var qsg_subgroups_s subgroups,
    input wire logic detectorCold,
    input wire logic selfTestFail,
    input wire logic questionableSummary,
    input wire logic [15:0] conditionView,
    input wire logic [15:0] eventView
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    wire logic pw = |(subgroups.power.events & subgroups.power.enable);
    wire logic qc = cmdValid && cmd.op == OP_QUERY_COND;
    wire logic qe = cmdValid && cmd.op == OP_QUERY_EVENT;
    wire logic clr = qe || (cmdValid && cmd.op == OP_CLEAR_STATUS);
    AST_ZERO: assert property ((conditionView & ~USED_MASK) == 16'h0000) else $error("b");
    AST_COLD: assert property ($past(resetn) |-> conditionView[4] == $past(detectorCold))
        else $error("cold");
    AST_POWER: assert property ($past(resetn) |-> conditionView[3] == $past(pw))
        else $error("pwr");
    AST_SELF: assert property (selfTestFail |=> conditionView[9]) else $error("st");
    AST_HOLD: assert property (conditionView[9] |=> conditionView[9]) else $error("sh");
    AST_COND: assert property (qc |=> rspValid && rspData == $past(conditionView))
        else $error("cq");
    AST_EVQ: assert property (qe |=> rspValid && rspData == $past(eventView))
        else $error("eq");
    AST_KEEP: assert property (!clr |=> (eventView & $past(eventView)) == $past(eventView))
        else $error("ek");
    AST_SUM: assert property (questionableSummary |-> eventView != 16'h0000) else $error("s");
    cover property (qe ##1 rspData != 16'h0000);
    cover property (questionableSummary);
    cover property ($rose(conditionView[9]));
endmodule // qsg_questionable_properties
bind qsg_questionable_status qsg_questionable_properties chk (.*);
`default_nettype wire

// ==== test/testbench.sv ====
`default_nettype none
module testbench;
    import qsg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, resetn = 1'h0, cold = 1'h0, stf = 1'h0;
    logic cmdValid, rspValid, summ;
    logic [15:0] rspData, cond, ev;
    qsg_cmd_s cmd;
    qsg_subgroups_s sg = '0;
    int err_count = 0, checks = 0;
    always #5 sys_clk = ~sys_clk;
    qsg_remote_ctl ctl (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmd(cmd));
    qsg_questionable_status DUT (.sys_clk(sys_clk), .resetn(resetn), .cmdValid(cmdValid),
        .cmd(cmd), .rspValid(rspValid), .rspData(rspData), .subgroups(sg),
        .detectorCold(cold), .selfTestFail(stf), .questionableSummary(summ),
        .conditionView(cond), .eventView(ev));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic ask(input qsg_op_e op, input logic [15:0] e);
        // Send returns just after the answering edge; the strobe stands now
        ctl.send(op, 16'h0000);
        chk("answer strobe", 16'h0001, {15'h0000, rspValid});
        chk(op.name(), e, rspData);
    endtask
    task automatic test_reset;
        ask(OP_QUERY_PTR, 16'h13B8);
        ask(OP_QUERY_NTR, 16'h0000);
        ask(OP_QUERY_ENABLE, 16'h0000);
        ask(OP_QUERY_EVENT, 16'h0000);
        $display("reset test done");
    endtask
    task automatic test_condition;
        sg = {5{32'h0008_0008}};
        cold = 1'h1;
        ctl.send(OP_WRITE_COND, 16'hFFFF);
        ask(OP_QUERY_COND, 16'h11B8);
        ask(OP_QUERY_EVENT, 16'h11B8);
        ask(OP_QUERY_EVENT, 16'h0000);
        $display("condition test done");
    endtask
    task automatic test_filters;
        ctl.send(OP_WRITE_PTR, 16'h0000);
        ctl.send(OP_WRITE_NTR, 16'h0018);
        ctl.send(OP_WRITE_ENABLE, 16'h0008);
        sg.power.events = 16'h0000;
        cold = 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk("summary", 16'h0001, {15'h0000, summ});
        ask(OP_QUERY_PTR, 16'h0000);
        ask(OP_QUERY_NTR, 16'h0018);
        ask(OP_QUERY_ENABLE, 16'h0008);
        ask(OP_QUERY_EVENT, 16'h0018);
        chk("summary cleared", 16'h0000, {15'h0000, summ});
        $display("filter test done");
    endtask
    task automatic test_self;
        stf = 1'h1;
        @(posedge sys_clk);
        #1 stf = 1'h0;
        ctl.send(OP_CLEAR_STATUS, 16'h0000);
        ask(OP_QUERY_COND, 16'h13A0);
        sg.freq.enable = 16'h0000;
        ask(OP_QUERY_COND, 16'h1380);
        $display("self test done");
    endtask
    task automatic close_out;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'h1;
        test_reset();
        test_condition();
        test_filters();
        test_self();
        close_out();
    end
    initial
    begin
        #20000 err_count++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
